/* logic/iss_pkg.sv */
/*
 * shared constants and types of the interrupt front end: i/o port map,
 * command word fields, reset values and serial frame timing.
 * assumes one pci-rate clock and an 8-bit i/o data path.
 */
package iss_pkg;
	// i/o port map
	localparam logic [15:0] CMD0_ADDR = 16'h0020;
	localparam logic [15:0] MASK0_ADDR = 16'h0021;
	localparam logic [15:0] MASK0_ALIAS = 16'h0061;
	localparam logic [15:0] CMD1_ADDR = 16'h00a0;
	localparam logic [15:0] MASK1_ADDR = 16'h00a1;
	localparam logic [15:0] ROUTE_BASE = 16'h0c00;
	localparam logic [15:0] SCFG_ADDR = 16'h0c04;
	// command word, route and serial setup field positions
	localparam int INIT_BIT = 4;
	localparam int CW3_BIT = 3;
	localparam int POLL_BIT = 2;
	localparam int RD_REG_BIT = 1;
	localparam int REG_SEL_BIT = 0;
	localparam int EOI_BIT = 5;
	localparam int ROUTE_OFF_BIT = 7;
	localparam int SCFG_QUIET_BIT = 3;
	// values after reset
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] ROUTE_RST = 8'h80;
	localparam logic [7:0] SCFG_RST = 8'h03;
	// levels a shared line may be steered to: 15,14,12..9,7..3
	localparam logic [15:0] STEER_OK = 16'hdef8;
	// serial frame timing, in clocks
	localparam logic [2:0] START_MIN = 3'h3;
	localparam logic [2:0] STOP_QUIET_CNT = 3'h1;
	localparam logic [2:0] STOP_CONT_CNT = 3'h2;
	localparam logic [5:0] LAST_FRAME = 6'h20;
	localparam logic [1:0] SAMPLE_PH = 2'h2;
	// serial frame targets beyond the 16 levels
	localparam logic [4:0] TGT_SMI = 5'h10;
	localparam logic [4:0] TGT_CHK = 5'h11;
	localparam logic [4:0] TGT_NONE = 5'h1f;

	typedef struct packed {
		logic [15:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} iss_io_req_type;

	typedef enum {S_IDLE, S_START, S_RISE, S_DATA, S_STOP, S_HIGH, S_GAP} iss_ser_state_type;
endpackage

/* logic/iss_irq_front.sv */
/*
 * interrupt front end: status readback of a two-controller request,
 * in-service and mask set, shared pci line steering, serial wire decoder.
 * assumes the priority core sits outside and gives ack and eoi strobes.
 */
// Functional notes
// - 8-bit pending register per controller; acknowledge clears lowest-numbered pending bit.
// - 8-bit in-service register; acknowledge sets it, end_of_interrupt clears it.
// - status read gives pending or in-service per register_select_bit.
// - status selection persists across reads until next control_word_three.
// - poll bit wins over read_register_bit; next command read is poll.
// - initialization word resets status selection to pending register.
// - mask address read returns the mask_bits of that controller.
// - four shared lines synchronised, steerable to eleven legal levels.
// - route low nibble picks level; bit seven disables that line.
// - several shared lines may land on one level, ORed.
// - shared lines active low and level sensitive.
// - after peripheral start, device drives low 3-7 more, high one, releases.
// - continuous mode after reset; device drives start low 4-8 clocks.
// - frames counted from start rising edge; sample, recovery, turn-around.
// - frame decode: 2 level 1, 3 smi, 4-8, 10-13, unused gaps.
// - frames 15-16 levels 14-15, 17 channel check, 18-21 pci lines.
// - frame three active drives external_smi_out_n low.
// - stop frame low 2 clocks selects quiet, 3 continuous.
// - next start no earlier than second clock after stop rising edge.
// - level_select_bits zero catches rising edge, one catches high level.
`timescale 1ns/100ps
module iss_irq_front (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// i/o register port
	input wire iss_pkg::iss_io_req_type io_req,
	output logic [7:0] io_rdata,
	// priority core side
	input wire logic [15:0] irq_in,
	input wire logic [15:0] level_select_bits,
	input wire logic [1:0] ack_in,
	input wire logic [1:0] eoi_in,
	output logic [1:0] ctrl_int,
	// shared pci lines
	input wire logic [3:0] shared_pci_irq_lines_n,
	// serial wire
	input wire logic serial_irq_wire_in,
	output logic serial_irq_wire_out,
	output logic serial_irq_wire_oe,
	// decoded sideband
	output logic external_smi_out_n,
	output logic io_channel_check_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	function automatic logic [7:0] lowest(input logic [7:0] x);
		lowest = x & 8'(~x + 8'h01);
	endfunction

	function automatic logic [2:0] index_of(input logic [7:0] x);
		index_of = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (x[i]) begin
				index_of = 3'(i);
			end
		end
	endfunction

	// frame number to target: 0..15 level, smi, channel check, pci a..d
	function automatic logic [4:0] frame_target(input logic [5:0] f);
		case (f)
			6'h02, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08,
			6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0f, 6'h10: begin
				frame_target = 5'(f - 6'h01);
			end
			6'h03: begin
				frame_target = iss_pkg::TGT_SMI;
			end
			6'h11, 6'h12, 6'h13, 6'h14, 6'h15: begin
				frame_target = 5'(f);
			end
			default: begin
				frame_target = iss_pkg::TGT_NONE;
			end
		endcase
	endfunction

	logic [1:0][7:0] pend_q, pend_d, isr_q, isr_d, mask_q, mask_d, stat_word;
	logic [1:0] sel_isr_q, sel_isr_d, poll_q, poll_d, rd_cmd, rd_mask;
	logic [3:0][7:0] route_q;
	logic [7:0] scfg_q, rdata_q, rdata_d;
	logic [15:0] prev_q, req_all, steered, ser_lvl_q, ser_lvl_d;
	logic [3:0] sync1_q, sync2_q, sync3_q, pirq_act_q, ser_pci_q, ser_pci_d, line_on;
	logic smi_q, smi_d, chk_q, chk_d, cont_q, cont_d, sample, act;
	logic route_wr, scfg_wr, rd_route, rd_scfg;
	logic [2:0] cnt_q, cnt_d, extra;
	logic [1:0] ph_q, ph_d;
	logic [5:0] fr_q, fr_d;
	logic [4:0] tgt;
	iss_pkg::iss_ser_state_type st_q, st_d;

	// shared line sync: three stages, a change counts once 2nd and 3rd agree
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_q <= 4'hf;
			sync2_q <= 4'hf;
			sync3_q <= 4'hf;
			pirq_act_q <= 4'h0;
		end else begin
			sync1_q <= shared_pci_irq_lines_n;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			pirq_act_q <= (~sync3_q & ~(sync2_q ^ sync3_q)) | (pirq_act_q & (sync2_q ^ sync3_q));
		end
	end

	// steering: a line is live if enabled and aimed at a legal level
	genvar gl;
	generate
		for (gl = 0; gl < 16; gl++) begin : g_lvl
			logic [3:0] hit;
			for (genvar gi = 0; gi < 4; gi++) begin : g_line
				assign hit[gi] = line_on[gi] && route_q[gi][3:0] == 4'(gl);
			end
			assign steered[gl] = |hit;
		end
		for (gl = 0; gl < 4; gl++) begin : g_on
			assign line_on[gl] = (pirq_act_q[gl] | ser_pci_q[gl])
				&& !route_q[gl][iss_pkg::ROUTE_OFF_BIT]
				&& iss_pkg::STEER_OK[route_q[gl][3:0]];
		end
	endgenerate

	// every request source meets here before the pending logic
	assign req_all = irq_in | ser_lvl_q | steered;

	// per-controller decode and next state
	generate
		for (gl = 0; gl < 2; gl++) begin : g_ctl
			logic [15:0] cmd_a, mask_a;
			logic [7:0] req, set, ackclr, eoiclr;
			logic cmd_wr, init_wr, cw3_wr, eoi_wr, ack, end_of_interrupt;
			assign cmd_a = (gl == 0) ? iss_pkg::CMD0_ADDR : iss_pkg::CMD1_ADDR;
			assign mask_a = (gl == 0) ? iss_pkg::MASK0_ADDR : iss_pkg::MASK1_ADDR;
			assign cmd_wr = io_req.wr && io_req.addr == cmd_a;
			assign init_wr = cmd_wr && io_req.wdata[iss_pkg::INIT_BIT];
			assign cw3_wr = cmd_wr && !init_wr && io_req.wdata[iss_pkg::CW3_BIT];
			assign eoi_wr = cmd_wr && !init_wr && !cw3_wr && io_req.wdata[iss_pkg::EOI_BIT];
			assign rd_cmd[gl] = io_req.rd && io_req.addr == cmd_a;
			assign rd_mask[gl] = io_req.rd && (io_req.addr == mask_a
				|| (gl == 0 && io_req.addr == iss_pkg::MASK0_ALIAS));
			assign req = req_all[gl*8 +: 8];
			// level mode takes the high level, edge mode only a rise
			assign set = (level_select_bits[gl*8 +: 8] & req)
				| (~level_select_bits[gl*8 +: 8] & req & ~prev_q[gl*8 +: 8]);
			// a poll read counts as an acknowledge
			assign ack = ack_in[gl] | (rd_cmd[gl] & poll_q[gl]);
			assign end_of_interrupt = eoi_in[gl] | eoi_wr;
			assign ackclr = ack ? lowest(pend_q[gl]) : 8'h00;
			assign eoiclr = end_of_interrupt ? lowest(isr_q[gl]) : 8'h00;
			// new request wins over the acknowledge clear; level bits drop with the input
			assign pend_d[gl] = (pend_q[gl] & ~ackclr
				& ~(level_select_bits[gl*8 +: 8] & ~req)) | set;
			assign isr_d[gl] = (isr_q[gl] & ~eoiclr) | ackclr;
			assign mask_d[gl] = init_wr ? iss_pkg::MASK_RST
				: (io_req.wr && io_req.addr == mask_a) ? io_req.wdata : mask_q[gl];
			assign sel_isr_d[gl] = init_wr ? 1'b0
				: (cw3_wr && io_req.wdata[iss_pkg::RD_REG_BIT])
				? io_req.wdata[iss_pkg::REG_SEL_BIT] : sel_isr_q[gl];
			assign poll_d[gl] = init_wr ? 1'b0 : cw3_wr ? io_req.wdata[iss_pkg::POLL_BIT]
				: rd_cmd[gl] ? 1'b0 : poll_q[gl];
			// poll word first, then the selected status register
			assign stat_word[gl] = poll_q[gl]
				? {|pend_q[gl], 4'h0, index_of(lowest(pend_q[gl]))}
				: sel_isr_q[gl] ? isr_q[gl] : pend_q[gl];
		end
	endgenerate

	// route and serial setup registers
	assign route_wr = io_req.wr && io_req.addr[15:2] == iss_pkg::ROUTE_BASE[15:2];
	assign scfg_wr = io_req.wr && io_req.addr == iss_pkg::SCFG_ADDR;
	assign rd_route = io_req.rd && io_req.addr[15:2] == iss_pkg::ROUTE_BASE[15:2];
	assign rd_scfg = io_req.rd && io_req.addr == iss_pkg::SCFG_ADDR;
	assign rdata_d = rd_cmd[0] ? stat_word[0] : rd_cmd[1] ? stat_word[1]
		: rd_mask[0] ? mask_q[0] : rd_mask[1] ? mask_q[1]
		: rd_route ? route_q[io_req.addr[1:0]] : rd_scfg ? scfg_q : 8'h00;

	// controller and i/o state; read data holds until the next read
	always_ff @(posedge clk) begin
		if (rst) begin
			pend_q <= '0;
			isr_q <= '0;
			mask_q <= {2{iss_pkg::MASK_RST}};
			sel_isr_q <= 2'h0;
			poll_q <= 2'h0;
			prev_q <= 16'h0000;
			route_q <= {4{iss_pkg::ROUTE_RST}};
			scfg_q <= iss_pkg::SCFG_RST;
			rdata_q <= 8'h00;
			ctrl_int <= 2'h0;
		end else begin
			pend_q <= pend_d;
			isr_q <= isr_d;
			mask_q <= mask_d;
			sel_isr_q <= sel_isr_d;
			poll_q <= poll_d;
			prev_q <= req_all;
			if (route_wr) begin
				route_q[io_req.addr[1:0]] <= io_req.wdata;
			end
			if (scfg_wr) begin
				scfg_q <= io_req.wdata;
			end
			if (io_req.rd) begin
				rdata_q <= rdata_d;
			end
			ctrl_int <= {|(pend_q[1] & ~mask_q[1]), |(pend_q[0] & ~mask_q[0])};
		end
	end
	assign io_rdata = rdata_q;

	// serial wire: start length is clamped so a short setting cannot break framing
	assign extra = (scfg_q[2:0] < iss_pkg::START_MIN) ? iss_pkg::START_MIN : scfg_q[2:0];
	assign sample = st_q == iss_pkg::S_DATA && ph_q == iss_pkg::SAMPLE_PH;
	assign act = !serial_irq_wire_in;
	assign tgt = frame_target(fr_q);

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		ph_d = ph_q;
		fr_d = fr_q;
		cont_d = cont_q;
		case (st_q)
			iss_pkg::S_IDLE: begin
				if (cont_q) begin
					st_d = iss_pkg::S_START;
					cnt_d = extra;
				end else if (!serial_irq_wire_in) begin
					st_d = iss_pkg::S_START;
					cnt_d = 3'(extra - 3'h1);
				end
			end
			iss_pkg::S_START: begin
				if (cnt_q == 3'h0) begin
					st_d = iss_pkg::S_RISE;
				end else begin
					cnt_d = 3'(cnt_q - 3'h1);
				end
			end
			iss_pkg::S_RISE: begin
				st_d = iss_pkg::S_DATA;
				ph_d = 2'h1;
				fr_d = 6'h01;
			end
			iss_pkg::S_DATA: begin
				if (ph_q == iss_pkg::SAMPLE_PH) begin
					ph_d = 2'h0;
					fr_d = 6'(fr_q + 6'h01);
					if (fr_q == iss_pkg::LAST_FRAME) begin
						st_d = iss_pkg::S_STOP;
						cont_d = !scfg_q[iss_pkg::SCFG_QUIET_BIT];
						cnt_d = scfg_q[iss_pkg::SCFG_QUIET_BIT]
							? iss_pkg::STOP_QUIET_CNT : iss_pkg::STOP_CONT_CNT;
					end
				end else begin
					ph_d = 2'(ph_q + 2'h1);
				end
			end
			iss_pkg::S_STOP: begin
				if (cnt_q == 3'h0) begin
					st_d = iss_pkg::S_HIGH;
				end else begin
					cnt_d = 3'(cnt_q - 3'h1);
				end
			end
			iss_pkg::S_HIGH: begin
				st_d = iss_pkg::S_GAP;
			end
			default: begin
				st_d = iss_pkg::S_IDLE;
			end
		endcase
	end

	// decoded frame values, each held until its own frame comes round again
	always_comb begin
		ser_lvl_d = ser_lvl_q;
		ser_pci_d = ser_pci_q;
		smi_d = smi_q;
		chk_d = chk_q;
		if (sample) begin
			if (!tgt[4]) begin
				ser_lvl_d[tgt[3:0]] = act;
			end else if (tgt == iss_pkg::TGT_SMI) begin
				smi_d = act;
			end else if (tgt == iss_pkg::TGT_CHK) begin
				chk_d = act;
			end else if (tgt != iss_pkg::TGT_NONE) begin
				ser_pci_d[2'(tgt[1:0] + 2'h2)] = act;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= iss_pkg::S_IDLE;
			cnt_q <= 3'h0;
			ph_q <= 2'h0;
			fr_q <= 6'h00;
			cont_q <= 1'b1;
			ser_lvl_q <= 16'h0000;
			ser_pci_q <= 4'h0;
			smi_q <= 1'b0;
			chk_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			ph_q <= ph_d;
			fr_q <= fr_d;
			cont_q <= cont_d;
			ser_lvl_q <= ser_lvl_d;
			ser_pci_q <= ser_pci_d;
			smi_q <= smi_d;
			chk_q <= chk_d;
		end
	end

	// open-collector drive: low in start and stop, one high clock after each
	assign serial_irq_wire_oe = st_q == iss_pkg::S_START || st_q == iss_pkg::S_RISE
		|| st_q == iss_pkg::S_STOP || st_q == iss_pkg::S_HIGH;
	assign serial_irq_wire_out = st_q == iss_pkg::S_RISE || st_q == iss_pkg::S_HIGH;
	assign external_smi_out_n = !smi_q;
	assign io_channel_check_n = !chk_q;

	chk_ack_sets_service: assert property (ack_in[0] && !eoi_in[0]
		|=> (isr_q[0] & $past(lowest(pend_q[0]))) == $past(lowest(pend_q[0])))
		else $error("acknowledge did not move pending bit to service");
	chk_eoi_clears: assert property (eoi_in[1] && !ack_in[1] && isr_q[1] != 8'h00
		|=> (isr_q[1] & $past(lowest(isr_q[1]))) == 8'h00)
		else $error("end of interrupt left service bit set");
	chk_status_read: assert property (rd_cmd[0] && !poll_q[0]
		|=> io_rdata == (sel_isr_q[0] ? $past(isr_q[0]) : $past(pend_q[0])))
		else $error("status read returned wrong register");
	chk_sel_holds: assert property (!(io_req.wr && io_req.addr == iss_pkg::CMD0_ADDR)
		|=> $stable(sel_isr_q[0]))
		else $error("status selection changed without a command write");
	// poll armed while in-service is selected: the poll word must still come back
	chk_poll_first: assert property (poll_q[0] && sel_isr_q[0] && rd_cmd[0]
		&& pend_q[0] == 8'h20 |=> io_rdata == 8'h85)
		else $error("poll answer did not win over status read");
	chk_init_sel: assert property (io_req.wr && io_req.addr == iss_pkg::CMD1_ADDR
		&& io_req.wdata[iss_pkg::INIT_BIT] |=> !sel_isr_q[1] && mask_q[1] == 8'h00)
		else $error("initialization did not select pending register");
	chk_mask_read: assert property (rd_mask[1] |=> io_rdata == $past(mask_q[1]))
		else $error("mask read returned wrong value");
	chk_steer_level: assert property ((pirq_act_q[3] || ser_pci_q[3])
		&& route_q[3] == 8'h0b |-> req_all[11])
		else $error("enabled shared line not steered to its level");
	chk_quiet_start: assert property (st_q == iss_pkg::S_IDLE && !cont_q
		&& !serial_irq_wire_in |=> serial_irq_wire_oe && !serial_irq_wire_out)
		else $error("device did not take over low after peripheral start");
	chk_stop_quiet: assert property (sample && fr_q == iss_pkg::LAST_FRAME
		&& scfg_q[iss_pkg::SCFG_QUIET_BIT]
		|=> (st_q == iss_pkg::S_STOP && !serial_irq_wire_out) [*2] ##1 st_q == iss_pkg::S_HIGH)
		else $error("quiet stop frame not two clocks low");
	chk_smi_frame: assert property (sample && fr_q == 6'h03 && act
		|=> !external_smi_out_n)
		else $error("smi frame did not raise external smi");

	cov_quiet_start: cover property (st_q == iss_pkg::S_IDLE && !cont_q && !serial_irq_wire_in);
	cov_poll_read: cover property (rd_cmd[0] && poll_q[0] && pend_q[0] != 8'h00);
	cov_two_lines: cover property (line_on[0] && line_on[1] && route_q[0] == route_q[1]);
endmodule

/* tb/iss_serial_periph.sv */
/*
 * serial interrupt peripheral model: open collector, pulls the wire low in
 * chosen sample slots and can start a frame while quiet mode is in force.
 * assumes the bench resolves the wire with a pull-up.
 */
`timescale 1ns/100ps
module iss_serial_periph (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// wire level and requests
	input wire logic wire_lvl,
	input wire logic [32:0] active,
	input wire logic start_req,
	// high while pulling the wire low
	output logic pull_low
);
	logic [7:0] slot_q;
	logic [7:0] run_q;
	logic [7:0] hi_q;
	logic pend_q;
	logic qpull_q;
	logic [7:0] frame;
	logic sample;
	// the clock never stops here, so no clock-run request is needed
	// frame n samples in slot 3n-1 counted from the start rising edge
	assign frame = (slot_q + 8'h01) / 8'h03;
	assign sample = slot_q % 8'h03 == 8'h02 && slot_q <= 8'h5f;
	// in its own sample slot only when active, or for one clock on a start request, else the pull-up holds
	assign pull_low = qpull_q || (sample && active[frame[5:0]]);
	// a low run of four or more is a start; its rising edge is slot 0
	always_ff @(posedge clk) begin
		if (rst) begin
			slot_q <= 8'hff;
			run_q <= 8'h00;
			hi_q <= 8'h00;
			pend_q <= 1'b0;
			qpull_q <= 1'b0;
		end else begin
			run_q <= wire_lvl ? 8'h00 : run_q + 8'h01;
			hi_q <= !wire_lvl ? 8'h00 : (hi_q == 8'hff ? hi_q : hi_q + 8'h01);
			slot_q <= (wire_lvl && run_q >= 8'h04) ? 8'h01 :
				(slot_q == 8'hff ? slot_q : slot_q + 8'h01);
			pend_q <= start_req || (pend_q && !qpull_q);
			// one clock low, not before the second clock of idle high
			qpull_q <= pend_q && !qpull_q && hi_q >= 8'h02;
		end
	end
endmodule

/* tb/iss_irq_front_tb_top.sv */
/*
 * self-checking bench of the interrupt front end.
 * assumes the serial peripheral model and a pull-up on the serial wire.
 */
`timescale 1ns/100ps
module iss_irq_front_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	iss_pkg::iss_io_req_type io_req = '0;
	logic [7:0] io_rdata;
	logic [15:0] irq_in = 16'h0000;
	logic [15:0] lvl = 16'h0000;
	logic [1:0] ack = 2'h0;
	logic [1:0] end_of_interrupt = 2'h0;
	logic [3:0] pci_n = 4'hf;
	logic [32:0] act = '0;
	logic sreq = 1'b0;
	logic w_out, w_oe, pull, smi_n, chk_n;
	logic [1:0] ctrl_int;
	logic [7:0] run_q = 8'h00;
	logic [7:0] last_start = 8'h00;
	logic [7:0] last_stop = 8'h00;
	int n_start = 0;
	int fails = 0;
	int n_checks = 0;
	wire wire_lvl = ((w_oe === 1'b1 && w_out === 1'b0) || pull === 1'b1) ? 1'b0 : 1'b1;

	always #5 clk = ~clk;

	iss_irq_front i_iss_irq_front (.clk(clk), .rst(rst), .io_req(io_req), .io_rdata(io_rdata),
		.irq_in(irq_in), .level_select_bits(lvl), .ack_in(ack), .eoi_in(end_of_interrupt),
		.ctrl_int(ctrl_int), .shared_pci_irq_lines_n(pci_n), .serial_irq_wire_in(wire_lvl),
		.serial_irq_wire_out(w_out), .serial_irq_wire_oe(w_oe),
		.external_smi_out_n(smi_n), .io_channel_check_n(chk_n));

	iss_serial_periph i_iss_serial_periph (.clk(clk), .rst(rst), .wire_lvl(wire_lvl),
		.active(act), .start_req(sreq), .pull_low(pull));

	// low runs of four or more are starts, two or three are stops, one is a sample
	always @(posedge clk) begin
		if (wire_lvl) begin
			if (run_q >= 8'h04) begin
				last_start <= run_q;
				n_start <= n_start + 1;
			end else if (run_q >= 8'h02) begin
				last_stop <= run_q;
			end
			run_q <= 8'h00;
		end else begin
			run_q <= run_q + 8'h01;
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic wcyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// one strobe cycle, then released a cycle later
	task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		io_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge clk);
		io_req.wr <= 1'b0;
	endtask

	// read data is loaded at the edge that takes the strobe
	task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		io_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge clk);
		io_req.rd <= 1'b0;
		#1;
		chk(io_rdata, exp);
	endtask

	task automatic t_reset;
		wcyc(8);
		chk(last_start, 8'h04);
		rdchk(16'h0021, 8'h00);
		rdchk(16'h0061, 8'h00);
		rdchk(16'h0c00, 8'h80);
		rdchk(16'h0020, 8'h00);
	endtask

	task automatic t_status;
		io_wr(16'h0021, 8'ha5);
		rdchk(16'h0061, 8'ha5);
		io_wr(16'h00a1, 8'h3c);
		rdchk(16'h00a1, 8'h3c);
		io_wr(16'h0021, 8'h28);
		@(posedge clk);
		irq_in <= 16'h0028;
		rdchk(16'h0020, 8'h28);
		chk({6'h00, ctrl_int}, 8'h00);
		@(posedge clk);
		ack <= 2'h1;
		@(posedge clk);
		ack <= 2'h0;
		rdchk(16'h0020, 8'h20);
		io_wr(16'h0020, 8'h0b);
		rdchk(16'h0020, 8'h08);
		io_wr(16'h0020, 8'h08);
		rdchk(16'h0020, 8'h08);
		io_wr(16'h0020, 8'h20);
		rdchk(16'h0020, 8'h00);
		io_wr(16'h0020, 8'h0f);
		rdchk(16'h0020, 8'h85);
		rdchk(16'h0020, 8'h20);
		@(posedge clk);
		irq_in <= 16'h0068;
		io_wr(16'h0020, 8'h10);
		rdchk(16'h0020, 8'h40);
		@(posedge clk);
		ack <= 2'h1;
		end_of_interrupt <= 2'h1;
		irq_in <= 16'h0000;
		@(posedge clk);
		ack <= 2'h0;
		end_of_interrupt <= 2'h0;
		io_wr(16'h00a0, 8'h10);
		rdchk(16'h00a1, 8'h00);
	endtask

	// both lines steered to level 10 in level mode
	task automatic t_steer;
		io_wr(16'h0c00, 8'h0a);
		io_wr(16'h0c01, 8'h0a);
		rdchk(16'h0c01, 8'h0a);
		pci_n <= 4'hd;
		wcyc(8);
		rdchk(16'h00a0, 8'h04);
		pci_n <= 4'hf;
		wcyc(8);
		rdchk(16'h00a0, 8'h00);
		pci_n <= 4'hc;
		wcyc(8);
		pci_n <= 4'hd;
		wcyc(8);
		// acknowledge and retire level 10; the held level sets it pending again
		@(posedge clk);
		ack <= 2'h2;
		@(posedge clk);
		ack <= 2'h0;
		end_of_interrupt <= 2'h2;
		@(posedge clk);
		end_of_interrupt <= 2'h0;
		rdchk(16'h00a0, 8'h04);
		chk({6'h00, ctrl_int}, 8'h02);
		io_wr(16'h0c01, 8'h8a);
		wcyc(8);
		rdchk(16'h00a0, 8'h00);
		pci_n <= 4'hf;
	endtask

	// serial frames 3, 5, 17 and 21 active; line d steered to level 11
	task automatic t_serial;
		io_wr(16'h0c03, 8'h0b);
		io_wr(16'h0c04, 8'h07);
		act <= 33'h000220028;
		wcyc(220);
		chk(smi_n, 8'h00);
		chk(chk_n, 8'h00);
		rdchk(16'h0020, 8'h10);
		rdchk(16'h00a0, 8'h08);
		chk(last_stop, 8'h03);
		chk(last_start, 8'h08);
		act <= '0;
		wcyc(220);
		chk(smi_n, 8'h01);
		rdchk(16'h0020, 8'h00);
	endtask

	task automatic t_quiet;
		int n0;
		io_wr(16'h0c04, 8'h0b);
		wcyc(220);
		chk(last_stop, 8'h02);
		n0 = n_start;
		wcyc(20);
		chk(8'(n_start - n0), 8'h00);
		sreq <= 1'b1;
		@(posedge clk);
		sreq <= 1'b0;
		wcyc(20);
		chk(8'(n_start - n0), 8'h01);
		chk(last_start, 8'h04);
	endtask

	task automatic summarize;
		$display("checks %0d, fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// level mode on levels 4, 10 and 11 for the steered and serial requests
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_status();
		lvl <= 16'h0c10;
		t_steer();
		t_serial();
		t_quiet();
		summarize();
	end

	// the whole run takes well under two thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		summarize();
	end
endmodule
